/* hdl/dpr_pkg.sv */
// dpr_pkg: constants and types for the bad pixel replacement stream block
// assumes one pixel clock; coordinates are columns and rows from the upper-left pixel
package dpr_pkg;
  localparam int DPR_PIX_W = 12;
  localparam int DPR_COORD_W = 12;
  localparam int DPR_MAP_MAX = 2048;
  localparam int DPR_IDX_W = 11;
  localparam int DPR_PTR_W = 12;
  localparam int DPR_LINE_DEPTH = 4096;
  localparam int DPR_MAP_DEPTH = 2 * DPR_MAP_MAX;
  localparam int DPR_ENTRY_W = 2 * DPR_COORD_W;
  localparam int DPR_WIN = 5;
  localparam int DPR_CENTER = 2;
  localparam int DPR_LATENCY = 4;
  localparam logic [DPR_PIX_W-1:0] DPR_PIX_RST = 12'h000;
  localparam logic [DPR_COORD_W-1:0] DPR_COORD_RST = 12'h000;
  localparam logic [DPR_PTR_W-1:0] DPR_PTR_RST = 12'h000;
  localparam logic [DPR_PTR_W-1:0] DPR_PTR_ONE = 12'h001;
  localparam logic [DPR_COORD_W-1:0] DPR_COORD_ONE = 12'h001;
  typedef enum logic
  {
    DPR_MAP_FACTORY,
    DPR_MAP_USER
  } dpr_map_e;
endpackage

/* hdl/dpr_mem.sv */
// dpr_mem: single-port-write, registered-read memory, read-before-write
// assumes write and read addresses are in range
`timescale 1ns/1ps
`default_nettype none
module dpr_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  // clock
  input wire logic ref_clk_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read side
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    rd_data_o <= mem[rd_addr_i];
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule
`default_nettype wire

/* hdl/dpr_top.sv */
// dpr_top: replaces mapped bad pixels in a gapless line stream
// assumes each map is loaded in raster order and pixels of a line arrive on consecutive cycles
// Functional notes
// - map entries are column/row from upper-left
// - map holds at most 2048 entries per source
// - decisions independent of 8/10/12-bit depth
// - factory or user map, selected per frame
// - preceding bad or absent: use next good
// - otherwise use preceding good pixel
// - mono, both neighbours bad: previous line pixel (code passes such pixels on the first row unchanged)
// - colour, both neighbours bad: pass unchanged
// - colour replacements only from same colour
`timescale 1ns/1ps
`default_nettype none
module dpr_top
  import dpr_pkg::*;
#(
  parameter int MAP_LIMIT = dpr_pkg::DPR_MAP_MAX
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic bayer_i,
  input wire logic map_sel_i,
  // map loading
  input wire logic map_wr_i,
  input wire logic map_bank_i,
  input wire logic [dpr_pkg::DPR_IDX_W-1:0] map_index_i,
  input wire logic [dpr_pkg::DPR_COORD_W-1:0] map_col_i,
  input wire logic [dpr_pkg::DPR_COORD_W-1:0] map_row_i,
  // pixel input stream
  input wire logic frame_start_i,
  input wire logic pix_valid_i,
  input wire logic pix_sol_i,
  input wire logic pix_sof_i,
  input wire logic [dpr_pkg::DPR_PIX_W-1:0] pix_data_i,
  // pixel output stream
  output logic out_valid_o,
  output logic out_sol_o,
  output logic out_sof_o,
  output logic out_replaced_o,
  output logic [dpr_pkg::DPR_PIX_W-1:0] out_data_o
);
  import dpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // position counters and map walk
  logic [DPR_COORD_W-1:0] col;
  logic [DPR_COORD_W-1:0] row;
  logic [DPR_PTR_W-1:0] ptr;
  logic [DPR_PTR_W-1:0] count [2];
  logic bank;
  logic line_tag;
  logic [DPR_ENTRY_W-1:0] entry;

  wire [DPR_COORD_W-1:0] cur_col = pix_sol_i ? DPR_COORD_RST : col;
  wire [DPR_COORD_W-1:0] cur_row = pix_sof_i ? DPR_COORD_RST : (pix_sol_i ? row + DPR_COORD_ONE : row);
  wire cur_tag = pix_sol_i ? ~line_tag : line_tag;
  wire next_bank = frame_start_i ? map_sel_i : bank;
  wire in_map = ptr < count[bank];
  wire hit = pix_valid_i && in_map && entry == {cur_col, cur_row};
  wire [DPR_PTR_W-1:0] next_ptr = frame_start_i ? DPR_PTR_RST : (hit ? ptr + DPR_PTR_ONE : ptr);
  wire [DPR_IDX_W:0] map_rd_addr = {next_bank, next_ptr[DPR_IDX_W-1:0]};
  wire load_ok = map_wr_i && ({1'b0, map_index_i} < MAP_LIMIT[DPR_PTR_W-1:0]);
  wire [DPR_PTR_W-1:0] load_len = {1'b0, map_index_i} + DPR_PTR_ONE;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col <= DPR_COORD_RST;
      row <= DPR_COORD_RST;
      ptr <= DPR_PTR_RST;
      bank <= 1'b0;
      line_tag <= 1'b0;
      count[0] <= DPR_PTR_RST;
      count[1] <= DPR_PTR_RST;
    end
    else
    begin
      ptr <= next_ptr;
      bank <= next_bank;
      if (pix_valid_i)
      begin
        col <= cur_col + DPR_COORD_ONE;
        row <= cur_row;
        line_tag <= cur_tag;
      end
      if (load_ok)
      begin
        count[map_bank_i] <= load_len;
      end
    end
  end

  dpr_mem #(
    .WIDTH(DPR_ENTRY_W),
    .DEPTH(DPR_MAP_DEPTH),
    .AW(DPR_IDX_W + 1)
  ) u_map (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(load_ok),
    .wr_addr_i({map_bank_i, map_index_i}),
    .wr_data_i({map_col_i, map_row_i}),
    .rd_addr_i(map_rd_addr),
    .rd_data_o(entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // previous line store, read before write at the same column
  logic [DPR_PIX_W-1:0] line_rd;

  dpr_mem #(
    .WIDTH(DPR_PIX_W),
    .DEPTH(DPR_LINE_DEPTH),
    .AW(DPR_COORD_W)
  ) u_line (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(pix_valid_i),
    .wr_addr_i(cur_col),
    .wr_data_i(pix_data_i),
    .rd_addr_i(cur_col),
    .rd_data_o(line_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // five pixel window, slot 0 oldest, slot 2 decided
  logic [DPR_PIX_W-1:0] s_data [DPR_WIN];
  logic [DPR_PIX_W-1:0] s_above [DPR_WIN];
  logic s_valid [DPR_WIN];
  logic s_flag [DPR_WIN];
  logic s_tag [DPR_WIN];
  logic s_first [DPR_WIN];
  logic s_sol [DPR_WIN];
  logic s_sof [DPR_WIN];

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < DPR_WIN; k++)
      begin
        s_data[k] <= DPR_PIX_RST;
        s_above[k] <= DPR_PIX_RST;
        s_valid[k] <= 1'b0;
        s_flag[k] <= 1'b0;
        s_tag[k] <= 1'b0;
        s_first[k] <= 1'b0;
        s_sol[k] <= 1'b0;
        s_sof[k] <= 1'b0;
      end
    end
    else
    begin
      for (int k = 0; k < DPR_WIN - 1; k++)
      begin
        s_data[k] <= s_data[k+1];
        s_above[k] <= (k == DPR_WIN - 2) ? line_rd : s_above[k+1];
        s_valid[k] <= s_valid[k+1];
        s_flag[k] <= s_flag[k+1];
        s_tag[k] <= s_tag[k+1];
        s_first[k] <= s_first[k+1];
        s_sol[k] <= s_sol[k+1];
        s_sof[k] <= s_sof[k+1];
      end
      s_data[DPR_WIN-1] <= pix_data_i;
      s_above[DPR_WIN-1] <= DPR_PIX_RST;
      s_valid[DPR_WIN-1] <= pix_valid_i;
      s_flag[DPR_WIN-1] <= hit;
      s_tag[DPR_WIN-1] <= cur_tag;
      s_first[DPR_WIN-1] <= cur_row == DPR_COORD_RST;
      s_sol[DPR_WIN-1] <= pix_sol_i;
      s_sof[DPR_WIN-1] <= pix_sof_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // replacement decision, full pixel word so any depth behaves alike
  wire c_valid = s_valid[DPR_CENTER];
  wire c_flag = s_flag[DPR_CENTER];
  wire p_mono = s_valid[1] && s_tag[1] == s_tag[DPR_CENTER] && !s_flag[1];
  wire n_mono = s_valid[3] && s_tag[3] == s_tag[DPR_CENTER] && !s_flag[3];
  wire p_bayer = s_valid[0] && s_tag[0] == s_tag[DPR_CENTER] && !s_flag[0];
  wire n_bayer = s_valid[4] && s_tag[4] == s_tag[DPR_CENTER] && !s_flag[4];
  wire p_ok = bayer_i ? p_bayer : p_mono;
  wire n_ok = bayer_i ? n_bayer : n_mono;
  wire [DPR_PIX_W-1:0] p_data = bayer_i ? s_data[0] : s_data[1];
  wire [DPR_PIX_W-1:0] n_data = bayer_i ? s_data[4] : s_data[3];
  wire use_next = c_flag && !p_ok && n_ok;
  wire use_prev = c_flag && p_ok;
  wire use_above = c_flag && !p_ok && !n_ok && !bayer_i && !s_first[DPR_CENTER];
  wire [DPR_PIX_W-1:0] sel_data = use_next ? n_data :
                                  use_prev ? p_data :
                                  use_above ? s_above[DPR_CENTER] : s_data[DPR_CENTER];

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid_o <= 1'b0;
      out_sol_o <= 1'b0;
      out_sof_o <= 1'b0;
      out_replaced_o <= 1'b0;
      out_data_o <= DPR_PIX_RST;
    end
    else
    begin
      out_valid_o <= c_valid;
      out_sol_o <= c_valid && s_sol[DPR_CENTER];
      out_sof_o <= c_valid && s_sof[DPR_CENTER];
      out_replaced_o <= c_valid && (use_next || use_prev || use_above);
      out_data_o <= sel_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_stream_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    out_valid_o == $past(pix_valid_i, 4)) else $error("output valid not four cycles after input");
  a_good_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && !c_flag |=> out_data_o == $past(s_data[DPR_CENTER]) && !out_replaced_o)
    else $error("unlisted pixel altered");
  a_next_used: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && c_flag && !p_ok && n_ok |=> out_data_o == $past(n_data) && out_replaced_o)
    else $error("next good pixel not used");
  a_prev_used: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && c_flag && p_ok |=> out_data_o == $past(p_data)) else $error("preceding good pixel not used");
  a_line_above: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && c_flag && !bayer_i && !s_first[DPR_CENTER] && !p_mono && !n_mono
    |=> out_data_o == $past(s_above[DPR_CENTER])) else $error("previous line pixel not used");
  a_colour_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && c_flag && bayer_i && !p_bayer && !n_bayer
    |=> out_data_o == $past(s_data[DPR_CENTER]) && !out_replaced_o) else $error("colour cluster altered");
  a_same_colour: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    c_valid && c_flag && bayer_i && (p_bayer || n_bayer)
    |=> out_data_o == $past(s_data[0]) || out_data_o == $past(s_data[4])) else $error("other colour used");
  a_map_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    count[0] <= MAP_LIMIT[DPR_PTR_W-1:0] && count[1] <= MAP_LIMIT[DPR_PTR_W-1:0])
    else $error("map length over limit");
  a_frame_rewind: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    frame_start_i |=> ptr == DPR_PTR_RST && bank == $past(map_sel_i)) else $error("map walk not restarted");
  a_origin_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    pix_valid_i && pix_sof_i |-> cur_col == DPR_COORD_RST && cur_row == DPR_COORD_RST)
    else $error("frame origin not at zero");
endmodule
`default_nettype wire

/* dv/dpr_sensor_model.sv */
// dpr_sensor_model: sensor side source of a small test frame
// assumes dpr_pkg; drives 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module dpr_sensor_model
  import dpr_pkg::*;
#(
  parameter int W = 8,
  parameter int H = 3
) (
  // clock
  input wire logic clk_i,
  // stream
  output logic fs_o,
  output logic valid_o,
  output logic sol_o,
  output logic sof_o,
  output logic [dpr_pkg::DPR_PIX_W-1:0] data_o
);
  import dpr_pkg::*;
  function automatic logic [DPR_PIX_W-1:0] px(int r, int c, logic [DPR_PIX_W-1:0] m);
    return (12'hf5a ^ DPR_PIX_W'(r * 16 + c)) & m;
  endfunction
  initial
  begin
    fs_o = 0;
    valid_o = 0;
    sol_o = 0;
    sof_o = 0;
    data_o = 12'h000;
  end
  ////////////////////////////////
  task automatic send(logic [DPR_PIX_W-1:0] m);
    @(posedge clk_i) #1 fs_o = 1;
    @(posedge clk_i) #1 fs_o = 0;
    for (int r = 0; r < H; r++)
    begin
      for (int c = 0; c < W; c++)
      begin
        @(posedge clk_i) #1 valid_o = 1;
        sol_o = (c == 0);
        sof_o = (c == 0 && r == 0);
        data_o = px(r, c, m);
      end
      // released line shows inverted data
      @(posedge clk_i) #1 valid_o = 0;
      sol_o = 0;
      sof_o = 0;
      data_o = ~data_o;
    end
  endtask
endmodule
`default_nettype wire

/* dv/dpr_top_tb_top.sv */
// dpr_top_tb_top: self-checking bench for bad pixel replacement
// assumes dpr_sensor_model as pixel source; bench is the formatter
`timescale 1ns/1ps
`default_nettype none
module dpr_top_tb_top;
  import dpr_pkg::*;
  localparam int W = 8;
  localparam int H = 3;
  logic ref_clk_i = 0;
  logic nrst_i = 0;
  logic bayer_i = 0;
  logic map_sel_i = 0;
  logic map_wr_i = 0;
  logic map_bank_i = 0;
  logic [DPR_IDX_W-1:0] map_index_i = '0;
  logic [DPR_COORD_W-1:0] map_col_i = '0;
  logic [DPR_COORD_W-1:0] map_row_i = '0;
  logic fs, pv, psol, psof, ov, osol, osof, orep;
  logic [DPR_PIX_W-1:0] pd, od;
  int mismatches = 0;
  int checked = 0;
  logic [DPR_LATENCY-1:0] pipe = '0;
  logic [15:0] expq[$];
  // map entries as row,column nibbles in raster order
  logic [7:0] fac[5] = '{8'h00, 8'h03, 8'h14, 8'h15, 8'h16};
  logic [7:0] usr[4] = '{8'h01, 8'h21, 8'h23, 8'h25};
  dpr_sensor_model sensor (.clk_i(ref_clk_i), .fs_o(fs), .valid_o(pv), .sol_o(psol), .sof_o(psof), .data_o(pd));
  dpr_top #(.MAP_LIMIT(8)) dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bayer_i(bayer_i), .map_sel_i(map_sel_i),
    .map_wr_i(map_wr_i), .map_bank_i(map_bank_i), .map_index_i(map_index_i), .map_col_i(map_col_i),
    .map_row_i(map_row_i), .frame_start_i(fs), .pix_valid_i(pv), .pix_sol_i(psol), .pix_sof_i(psof),
    .pix_data_i(pd), .out_valid_o(ov), .out_sol_o(osol), .out_sof_o(osof), .out_replaced_o(orep), .out_data_o(od));
  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(logic ok, string m);
    checked++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(logic b, int i, logic [7:0] rc);
    @(posedge ref_clk_i) #1 map_wr_i = 1;
    map_bank_i = b;
    map_index_i = DPR_IDX_W'(i);
    map_row_i = DPR_COORD_W'(rc[7:4]);
    map_col_i = DPR_COORD_W'(rc[3:0]);
    @(posedge ref_clk_i) #1 map_wr_i = 0;
  endtask
  function automatic bit good(logic s, int r, int c);
    logic [7:0] k;
    k = 8'(r * 16 + c);
    if (c < 0 || c >= W)
      return 0;
    foreach (fac[i]) if (!s && fac[i] == k) return 0;
    foreach (usr[i]) if (s && usr[i] == k) return 0;
    return 1;
  endfunction
  task automatic frame(logic b, logic s, logic [DPR_PIX_W-1:0] m);
    int d;
    int n;
    logic [15:0] e;
    d = b ? 2 : 1;
    @(posedge ref_clk_i) #1 bayer_i = b;
    map_sel_i = s;
    for (int r = 0; r < H; r++)
      for (int c = 0; c < W; c++)
      begin
        e = {1'b0, r == 0 && c == 0, c == 0, 1'b0, sensor.px(r, c, m)};
        if (!good(s, r, c) && good(s, r, c - d))
          e[12:0] = {1'b1, sensor.px(r, c - d, m)};
        else if (!good(s, r, c) && good(s, r, c + d))
          e[12:0] = {1'b1, sensor.px(r, c + d, m)};
        else if (!good(s, r, c) && !b && r > 0)
          e[12:0] = {1'b1, sensor.px(r - 1, c, m)};
        expq.push_back(e);
      end
    sensor.send(m);
    n = 0;
    while (expq.size() > 0 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    if (expq.size() > 0)
    begin
      chk(0, "output stream stalled");
      results();
    end
  endtask
  // output check at the falling edge, where outputs are settled
  always @(negedge ref_clk_i)
  begin
    pipe <= {pipe[DPR_LATENCY-2:0], pv};
    if (nrst_i)
      chk(ov === pipe[DPR_LATENCY-1], "output timing");
    if (ov === 1'b1)
    begin
      chk(expq.size() > 0 && {1'b0, osof, osol, orep, od} === expq[0], "pixel value or flags");
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  end
  ////////////////////////////////
  task automatic t_mono();
    frame(0, 0, 12'hfff);
  endtask
  task automatic t_colour();
    frame(1, 1, 12'hfff);
  endtask
  task automatic t_colour_fac();
    frame(1, 0, 12'h0ff);
  endtask
  task automatic t_refuse();
    wr(1, 8, 8'h26);
    frame(0, 1, 12'h3ff);
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    chk(ov === 1'b0 && od === 12'h000, "outputs not idle in reset");
    #1 nrst_i = 1;
    repeat (3) @(posedge ref_clk_i);
    foreach (fac[i]) wr(0, i, fac[i]);
    foreach (usr[i]) wr(1, i, usr[i]);
    t_mono();
    t_colour();
    t_colour_fac();
    t_refuse();
    results();
  end
endmodule
`default_nettype wire
